// File: inc/acr_pkg.sv
// Shared constants and types for the converter control and result register block.
package acr_pkg;

  localparam int unsigned ACR_RESULT_BITS = 10;
  localparam int unsigned ACR_PRESC_BITS = 7;

  // Printed register offsets are register indexes; byte address is four times the index.
  localparam logic [7:0] ACR_IDX_RESULT_LOW = 8'h78;
  localparam logic [7:0] ACR_IDX_RESULT_HIGH = 8'h79;
  localparam logic [7:0] ACR_IDX_CONTROL = 8'h7A;
  localparam logic [7:0] ACR_IDX_TRIGGER = 8'h7B;
  localparam logic [7:0] ACR_IDX_INPUT_REF = 8'h7C;
  localparam logic [31:0] ACR_ADDR_RESULT_LOW = {22'h000000, ACR_IDX_RESULT_LOW, 2'h0};
  localparam logic [31:0] ACR_ADDR_RESULT_HIGH = {22'h000000, ACR_IDX_RESULT_HIGH, 2'h0};
  localparam logic [31:0] ACR_ADDR_CONTROL = {22'h000000, ACR_IDX_CONTROL, 2'h0};
  localparam logic [31:0] ACR_ADDR_TRIGGER = {22'h000000, ACR_IDX_TRIGGER, 2'h0};
  localparam logic [31:0] ACR_ADDR_INPUT_REF = {22'h000000, ACR_IDX_INPUT_REF, 2'h0};

  // Field positions of the control and status register.
  localparam int ACR_CS_ENABLE = 7;
  localparam int ACR_CS_START = 6;
  localparam int ACR_CS_AUTO = 5;
  localparam int ACR_CS_FLAG = 4;
  localparam int ACR_CS_IRQ_EN = 3;
  localparam int ACR_CS_DIV_HI = 2;

  // Field positions of the input and reference selection register and of the trigger register.
  localparam int ACR_IR_REF_HI = 7;
  localparam int ACR_IR_REF_LO = 6;
  localparam int ACR_IR_LEFT = 5;
  localparam int ACR_IR_CHAN_HI = 3;
  localparam int ACR_IR_TRIG_HI = 2;

  localparam logic [1:0] ACR_REF_EXTERNAL = 2'h0;
  localparam logic [1:0] ACR_REF_SUPPLY = 2'h1;
  localparam logic [1:0] ACR_REF_RESERVED = 2'h2;
  localparam logic [1:0] ACR_REF_BANDGAP = 2'h3;
  localparam logic [3:0] ACR_CHAN_LAST_PIN = 4'h7;
  localparam logic [3:0] ACR_CHAN_BANDGAP = 4'hE;
  localparam logic [3:0] ACR_CHAN_GROUND = 4'hF;
  localparam logic [2:0] ACR_TRIG_FREE_RUN = 3'h0;

  localparam logic [4:0] ACR_FIRST_CONV_CLOCKS = 5'h19;
  localparam logic [4:0] ACR_NORMAL_CONV_CLOCKS = 5'h0D;
  localparam logic [4:0] ACR_SAR_CLOCKS = 5'h0A;
  localparam logic [9:0] ACR_SAR_FIRST_PROBE = 10'h200;
  localparam logic [2:0] ACR_DIV_SEL_MIN = 3'h1;

  typedef enum logic [1:0] {
    ACR_CONV_IDLE = 2'h0,
    ACR_CONV_SAMPLE = 2'h1,
    ACR_CONV_APPROX = 2'h3
  } acr_conv_t;

  typedef struct packed {
    logic powered;
    logic sampling;
    logic [1:0] ref_sel;
    logic [3:0] chan_sel;
    logic [9:0] trial_code;
  } acr_afe_t;

  typedef struct packed {
    acr_conv_t conv;
    logic [1:0] ref_sel;
    logic left_adjust;
    logic [3:0] chan_sel;
    logic enable;
    logic auto_trig;
    logic done_flag;
    logic irq_en;
    logic [2:0] div_sel;
    logic [2:0] trig_sel;
    logic first_pending;
    logic [6:0] presc;
    logic [4:0] tick_cnt;
    logic [4:0] conv_len;
    logic [9:0] probe;
    logic [9:0] result;
    logic read_lock;
    logic trig_prev;
    logic cmp_meta;
    logic cmp_sync;
    logic dphase;
    logic dwrite;
    logic [31:0] daddr;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic irq;
    acr_afe_t afe;
  } acr_state_t;

  localparam acr_state_t ACR_STATE_RESET = '{conv: ACR_CONV_IDLE, first_pending: 1'b1, hreadyout: 1'b1, default: '0};

endpackage

// File: src/acr_adc_ctrl.sv
// Converter control, prescaler, successive approximation sequencer and result registers on AHB-Lite.
//
// Contract
// RULE_01: Ten-bit code is linear in input over reference, zero to all ones.
// RULE_02: Reference field picks external pin, analog supply, reserved, or internal bandgap.
// RULE_03: Reference and channel writes during a conversion apply once it completes.
// RULE_04: Left adjust bit changes the visible result layout immediately, even mid conversion.
// RULE_05: Bit four of the selection register reads zero and ignores writes.
// RULE_06: Channel field picks pins 0-7, bandgap at 1110, ground at 1111.
// RULE_07: Enable one powers the converter; zero powers it off and aborts conversion.
// RULE_08: Start bit begins a conversion; first after enable takes 25 clocks, else 13.
// RULE_09: Start reads one while converting, zero after; writing zero does nothing.
// RULE_10: With auto trigger on, each rising edge of selected trigger starts conversion.
// RULE_11: Done flag sets when a conversion completes and results are updated.
// RULE_12: Done flag clears on vector taken or writing one; zero leaves it.
// RULE_13: Interrupt requested while flag, its enable and global enable are all set.
// RULE_14: Converter clock is system clock divided by 2,2,4,8,16,32,64,128.
// RULE_15: Right aligned: low byte holds bits 7:0, high byte bits 1:0 hold 9:8.
// RULE_16: Left aligned: high byte holds bits 9:2, low byte bits 7:6 hold 1:0.
// RULE_17: After low byte read, both bytes hold until high byte is read.
// RULE_18: Software reads low byte first; reading only high is fine when left aligned.
// RULE_19: Trigger source ignored without auto trigger; zero is free running, others events.
// RULE_20: Free running restarts at completion, so later channel changes skip one conversion.
// RULE_21: Abort by disabling clears start, keeps results and leaves the done flag.
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none

module acr_adc_ctrl
  import acr_pkg::*;
#(
  parameter int unsigned TRIGGER_COUNT = 7
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic comparator_above,
  input wire logic [TRIGGER_COUNT-1:0] trigger_sources,
  input wire logic global_irq_enable,
  input wire logic irq_vector_taken,
  output logic irq_request,
  output acr_afe_t afe_ctrl
);

  acr_state_t s;
  acr_state_t n;

  // Only whole-word transfers are issued, so the transfer size needs no decoding.
  logic size_unused;
  logic addr_accept;
  logic wr_go;
  logic rd_go;
  logic [7:0] wbyte;
  logic [2:0] div_shift;
  logic [7:0] div_mask_wide;
  logic [6:0] div_mask;
  logic adc_tick;
  logic trig_level;
  logic [2:0] trig_index;
  logic [7:0] low_view;
  logic [7:0] high_view;
  logic [7:0] control_view;
  logic [7:0] inref_view;
  logic [4:0] tick_next;
  logic [9:0] sar_kept;
  logic hit_low;
  logic hit_high;
  logic hit_control;
  logic hit_trigger;
  logic hit_inref;

  assign size_unused = ^hsize;
  assign addr_accept = hsel & htrans[1] & hready;
  assign wr_go = s.dphase & s.dwrite;
  assign rd_go = s.dphase & ~s.dwrite;
  assign wbyte = hwdata[7:0];

  // Selections 000 and 001 both give the smallest divider.
  assign div_shift = (s.div_sel == 3'h0) ? 3'h0 : s.div_sel - ACR_DIV_SEL_MIN; // [RULE_14]
  assign div_mask_wide = (8'h02 << div_shift) - 8'h01; // [RULE_14]
  assign div_mask = div_mask_wide[6:0];
  assign adc_tick = s.enable & ((s.presc & div_mask) == div_mask); // [RULE_14]
  // The prescaler restarts from zero on enable, so the first tick comes a full divider period
  // after the start; a running prescaler gives a first tick anywhere within one period.

  // Trigger inputs are flags of peripherals on this clock, so no synchroniser is needed.
  assign trig_index = s.trig_sel - 3'h1;
  assign trig_level = (s.trig_sel != ACR_TRIG_FREE_RUN) & trigger_sources[trig_index]; // [RULE_19]

  // The layout follows the live left adjust bit, not the one at conversion time.
  assign low_view = s.left_adjust ? {s.result[1:0], 6'h00} : s.result[7:0]; // [RULE_04] [RULE_15] [RULE_16]
  assign high_view = s.left_adjust ? s.result[9:2] : {6'h00, s.result[9:8]}; // [RULE_04] [RULE_15] [RULE_16]
  assign control_view = {s.enable, (s.conv != ACR_CONV_IDLE), s.auto_trig, s.done_flag, s.irq_en, s.div_sel}; // [RULE_09]
  assign inref_view = {s.ref_sel, s.left_adjust, 1'b0, s.chan_sel}; // [RULE_05]

  assign tick_next = s.tick_cnt + 5'h01;
  // A low comparator answer means the input sits below the trial code, so the probed bit drops.
  assign sar_kept = s.cmp_sync ? s.afe.trial_code : (s.afe.trial_code & ~s.probe); // [RULE_01]
  // Limitation: the comparator must settle and pass both synchroniser flops within one
  // converter clock of a new trial code, which bounds the smallest usable divider.

  // Address decode of the registered data-phase address; an unmapped word hits nothing.
  always_comb begin
    hit_low = 1'b0;
    hit_high = 1'b0;
    hit_control = 1'b0;
    hit_trigger = 1'b0;
    hit_inref = 1'b0;
    if (s.daddr == ACR_ADDR_RESULT_LOW) begin
      hit_low = 1'b1;
    end else if (s.daddr == ACR_ADDR_RESULT_HIGH) begin
      hit_high = 1'b1;
    end else if (s.daddr == ACR_ADDR_CONTROL) begin
      hit_control = 1'b1;
    end else if (s.daddr == ACR_ADDR_TRIGGER) begin
      hit_trigger = 1'b1;
    end else if (s.daddr == ACR_ADDR_INPUT_REF) begin
      hit_inref = 1'b1;
    end
  end

  always_comb begin
    logic start_req;
    logic completing;
    start_req = 1'b0;
    completing = 1'b0;
    n = s;

    n.cmp_meta = comparator_above;
    n.cmp_sync = s.cmp_meta;
    n.trig_prev = trig_level;
    n.presc = s.enable ? s.presc + 7'h01 : 7'h00;


    if (wr_go && hit_inref) begin
      n.ref_sel = wbyte[ACR_IR_REF_HI:ACR_IR_REF_LO]; // [RULE_02]
      n.left_adjust = wbyte[ACR_IR_LEFT]; // [RULE_04]
      n.chan_sel = wbyte[ACR_IR_CHAN_HI:0]; // [RULE_06]
    end else if (wr_go && hit_trigger) begin
      n.trig_sel = wbyte[ACR_IR_TRIG_HI:0];
    end else if (wr_go && hit_control) begin
      n.enable = wbyte[ACR_CS_ENABLE]; // [RULE_07]
      n.auto_trig = wbyte[ACR_CS_AUTO];
      n.irq_en = wbyte[ACR_CS_IRQ_EN];
      n.div_sel = wbyte[ACR_CS_DIV_HI:0];
      if (wbyte[ACR_CS_FLAG]) begin
        n.done_flag = 1'b0; // [RULE_12]
      end
      start_req = wbyte[ACR_CS_START]; // [RULE_09]
    end


    if (irq_vector_taken) begin
      n.done_flag = 1'b0; // [RULE_12]
    end


    // Auto trigger fires on a rising edge only; sources are ignored while it is off.
    if (n.auto_trig && trig_level && !s.trig_prev) begin
      start_req = 1'b1; // [RULE_10] [RULE_19]
    end


    if (!n.enable) begin
      n.conv = ACR_CONV_IDLE; // [RULE_07] [RULE_21]
      n.first_pending = 1'b1; // [RULE_08]
      n.afe.sampling = 1'b0;
    end else if (s.conv == ACR_CONV_IDLE) begin
      if (start_req) begin
        n.conv = ACR_CONV_SAMPLE; // [RULE_08]
        n.tick_cnt = 5'h00;
        n.conv_len = s.first_pending ? ACR_FIRST_CONV_CLOCKS : ACR_NORMAL_CONV_CLOCKS; // [RULE_08]
        n.first_pending = 1'b0;
        n.afe.sampling = 1'b1;
      end
    end else if (adc_tick) begin
      n.tick_cnt = tick_next;
      if (s.conv == ACR_CONV_SAMPLE) begin
        if (tick_next == s.conv_len - ACR_SAR_CLOCKS) begin
          n.conv = ACR_CONV_APPROX;
          n.afe.sampling = 1'b0;
          n.afe.trial_code = ACR_SAR_FIRST_PROBE;
          n.probe = ACR_SAR_FIRST_PROBE;
        end
      end else begin
        n.probe = s.probe >> 1;
        n.afe.trial_code = sar_kept | (s.probe >> 1); // [RULE_01]
        if (tick_next == s.conv_len) begin
          completing = 1'b1;
        end
      end
    end


    // Completion is applied after the software and vector clears, so its set of the flag wins.
    if (completing) begin
      n.conv = ACR_CONV_IDLE; // [RULE_09]
      n.afe.trial_code = sar_kept;
      // A result that lands while a read pair is open is dropped to keep the pair consistent.
      if (!s.read_lock) begin
        n.result = sar_kept; // [RULE_11] [RULE_17]
      end
      n.done_flag = 1'b1; // [RULE_11]
      if (n.auto_trig && (n.trig_sel == ACR_TRIG_FREE_RUN)) begin
        n.conv = ACR_CONV_SAMPLE; // [RULE_20]
        n.tick_cnt = 5'h00;
        n.conv_len = ACR_NORMAL_CONV_CLOCKS; // [RULE_20]
        n.afe.sampling = 1'b1;
      end
    end


    // Selections reach the front end only between conversions or at a restart.
    if ((n.conv == ACR_CONV_IDLE) || (n.conv == ACR_CONV_SAMPLE && s.conv != ACR_CONV_SAMPLE)) begin
      n.afe.ref_sel = n.ref_sel; // [RULE_03] [RULE_02]
      n.afe.chan_sel = n.chan_sel; // [RULE_03] [RULE_06]
    end
    n.afe.powered = n.enable; // [RULE_07]


    n.irq = n.done_flag & n.irq_en & global_irq_enable; // [RULE_13]


    // Every transfer takes one wait state, which keeps the register decode off the address phase.
    n.hresp = 1'b0;
    if (s.dphase) begin
      n.dphase = 1'b0;
      n.hreadyout = 1'b1;
      n.hrdata = 32'h00000000;
      if (rd_go) begin
        if (hit_low) begin
          n.hrdata = {24'h000000, low_view};
          n.read_lock = 1'b1; // [RULE_17]
        end else if (hit_high) begin
          n.hrdata = {24'h000000, high_view};
          n.read_lock = 1'b0; // [RULE_17]
        end else if (hit_control) begin
          n.hrdata = {24'h000000, control_view};
        end else if (hit_trigger) begin
          n.hrdata = {29'h00000000, s.trig_sel};
        end else if (hit_inref) begin
          n.hrdata = {24'h000000, inref_view};
        end
      end
    end else if (addr_accept) begin
      n.dphase = 1'b1;
      n.dwrite = hwrite;
      n.daddr = haddr;
      n.hreadyout = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= ACR_STATE_RESET;
    end else begin
      s <= n;
    end
  end

  assign hreadyout = s.hreadyout;
  assign hresp = s.hresp | (size_unused & 1'b0);
  assign hrdata = s.hrdata;
  assign irq_request = s.irq;
  assign afe_ctrl = s.afe;

endmodule

`default_nettype wire

// File: tb/acr_adc_ctrl_chk.sv
// Port-level assertions for the converter control block.
`timescale 1ns/10ps
`default_nettype none
module acr_adc_ctrl_chk
  import acr_pkg::*;
#(
  parameter int unsigned TRIGGER_COUNT = 7
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic comparator_above,
  input wire logic [TRIGGER_COUNT-1:0] trigger_sources,
  input wire logic global_irq_enable,
  input wire logic irq_vector_taken,
  input wire logic irq_request,
  input wire acr_afe_t afe_ctrl
);
  default clocking dc @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  chk_one_wait: assert property (hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
    else $error("transfer did not take one wait state");
  chk_ready_back: assert property (!hreadyout |=> hreadyout)
    else $error("wait state longer than one cycle");
  chk_resp_okay: assert property (!hresp)
    else $error("response other than okay");
  chk_rdata_upper: assert property (hrdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  chk_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data changed between transfers");
  chk_irq_global: assert property (irq_request |-> $past(global_irq_enable))
    else $error("interrupt without global enable");
  chk_vector_clear: assert property (irq_vector_taken |-> ##2 !irq_request)
    else $error("interrupt kept after vector taken");
  chk_off_idle: assert property (!afe_ctrl.powered |-> !afe_ctrl.sampling)
    else $error("sampling while powered off");
  chk_sel_hold: assert property (afe_ctrl.sampling && $past(afe_ctrl.sampling)
    |-> $stable(afe_ctrl.chan_sel) && $stable(afe_ctrl.ref_sel))
    else $error("selection changed during sampling");
endmodule
`default_nettype wire

// File: tb/acr_adc_ctrl_tb.sv
// Self-checking testbench for the converter control block.
`timescale 1ns/10ps
`default_nettype none
module acr_adc_ctrl_tb;
  import acr_pkg::*;
  localparam logic [31:0] AL = ACR_ADDR_RESULT_LOW;
  localparam logic [31:0] AH = ACR_ADDR_RESULT_HIGH;
  localparam logic [31:0] AC = ACR_ADDR_CONTROL;
  localparam logic [31:0] AI = ACR_ADDR_INPUT_REF;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [6:0] trig = 7'h00;
  logic gie = 1'b0;
  logic vec = 1'b0;
  logic cmp = 1'b0;
  logic [9:0] vin = 10'h000;
  logic [31:0] rd;
  wire logic hreadyout;
  wire logic hresp;
  wire logic irq;
  wire logic [31:0] hrdata;
  wire acr_afe_t afe;
  int miscompares = 0;
  int cmp_count = 0;
  acr_adc_ctrl #(.TRIGGER_COUNT(7)) acr_adc_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .comparator_above(cmp), .trigger_sources(trig),
    .global_irq_enable(gie), .irq_vector_taken(vec), .irq_request(irq), .afe_ctrl(afe));
  initial forever #12.5 hclk = ~hclk;
  // The comparator answers the trial code like an ideal input, one register late.
  always @(posedge hclk) cmp <= (vin >= afe.trial_code);
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Converter clock is system clock over eight in every run below.
  task automatic run_conv(input logic [31:0] c, input logic [31:0] ir, input logic [3:0] och, input int len);
    bus(1'b1, AC, c);
    bus(1'b1, AI, ir);
    chk("chan_held", {28'h0, afe.chan_sel}, {28'h0, och});
    idle(len * 8 - 23);
    bus(1'b0, AC, 32'h0);
    chk("busy", {31'h0, rd[6]}, 32'h1);
    idle(30);
    bus(1'b0, AC, 32'h0);
    chk("done", {30'h0, rd[6], rd[4]}, 32'h1);
  endtask
  task automatic t_reset;
    logic [31:0] regs [6];
    regs = '{AL, AH, AC, ACR_ADDR_TRIGGER, AI, 32'h200};
    bus(1'b1, AL, 32'hFF);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, regs[i], 32'h0);
      chk("reset_value", rd, 32'h0);
    end
  endtask
  task automatic t_convert;
    bus(1'b1, AI, 32'hFF);
    bus(1'b0, AI, 32'h0);
    chk("ir_bit4", rd, 32'hEF);
    bus(1'b1, AI, 32'h03);
    vin <= 10'h2A5;
    run_conv(32'hC3, 32'h03, 4'h3, 25);
    bus(1'b0, AL, 32'h0);
    chk("low_right", rd, 32'hA5);
    bus(1'b0, AH, 32'h0);
    chk("high_right", rd, 32'h02);
    bus(1'b1, AI, 32'h23);
    bus(1'b0, AL, 32'h0);
    chk("low_left", rd, 32'h40);
    bus(1'b0, AH, 32'h0);
    chk("high_left", rd, 32'hA9);
  endtask
  // A conversion ends while the pair is locked, so its result must not show.
  task automatic t_lock;
    bus(1'b0, AL, 32'h0);
    vin <= 10'h155;
    run_conv(32'hD3, 32'h2E, 4'h3, 13);
    chk("chan_new", {28'h0, afe.chan_sel}, 32'hE);
    bus(1'b0, AH, 32'h0);
    chk("high_locked", rd, 32'hA9);
    bus(1'b1, AC, 32'h9B);
    bus(1'b0, AC, 32'h0);
    chk("flag_w1c", rd, 32'h8B);
  endtask
  task automatic t_auto;
    gie <= 1'b1;
    bus(1'b1, ACR_ADDR_TRIGGER, 32'h1);
    bus(1'b1, AC, 32'hAB);
    idle(4);
    bus(1'b0, AC, 32'h0);
    chk("no_trigger", rd, 32'hAB);
    trig <= 7'h01;
    idle(3);
    bus(1'b0, AC, 32'h0);
    chk("trig_start", {31'h0, rd[6]}, 32'h1);
    idle(130);
    chk("irq_on", {31'h0, irq}, 32'h1);
    vec <= 1'b1;
    @(posedge hclk);
    vec <= 1'b0;
    idle(3);
    chk("irq_off", {31'h0, irq}, 32'h0);
    bus(1'b0, AC, 32'h0);
    chk("flag_vector", rd, 32'hAB);
    trig <= 7'h00;
  endtask
  task automatic t_abort;
    bus(1'b1, AC, 32'hC3);
    idle(20);
    bus(1'b1, AC, 32'h03);
    bus(1'b0, AC, 32'h0);
    chk("abort_now", rd, 32'h03);
    idle(250);
    bus(1'b0, AC, 32'h0);
    chk("abort_later", rd, 32'h03);
    chk("powered", {31'h0, afe.powered}, 32'h0);
    bus(1'b0, AL, 32'h0);
    chk("abort_low", rd, 32'h40);
    bus(1'b0, AH, 32'h0);
    chk("abort_high", rd, 32'h55);
  endtask
  // Free running restarts at completion, so a channel write then reaches only the conversion after next.
  task automatic t_free;
    vin <= 10'h0F0;
    bus(1'b1, ACR_ADDR_TRIGGER, 32'h0);
    bus(1'b1, AC, 32'hE3);
    idle(210);
    bus(1'b0, AC, 32'h0);
    chk("free_restart", rd, 32'hF3);
    bus(1'b1, AI, 32'h25);
    chk("free_chan_held", {28'h0, afe.chan_sel}, 32'hE);
    idle(100);
    chk("free_chan_new", {28'h0, afe.chan_sel}, 32'h5);
    bus(1'b1, AC, 32'h03);
    bus(1'b0, AC, 32'h0);
    chk("flag_w0", rd, 32'h13);
    bus(1'b0, AL, 32'h0);
    chk("free_low", rd, 32'h00);
    bus(1'b0, AH, 32'h0);
    chk("free_high", rd, 32'h3C);
  endtask
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #500000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_convert();
    t_lock();
    t_auto();
    t_abort();
    t_free();
    tally_and_finish();
  end
endmodule
bind acr_adc_ctrl acr_adc_ctrl_chk #(.TRIGGER_COUNT(TRIGGER_COUNT)) chk_inst (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .comparator_above(comparator_above),
  .trigger_sources(trigger_sources), .global_irq_enable(global_irq_enable), .irq_vector_taken(irq_vector_taken),
  .irq_request(irq_request), .afe_ctrl(afe_ctrl));
`default_nettype wire
